// ===== rtl/rct_timer.sv
// Repeat cycle timer evaluated once per controller scan tick.
// Assumes all inputs come from logic on i_sys_clk; ticks are one cycle.
//
// Function
// - While run is high, pulse high for high interval, then low.
// - Dropping run forces the pulse low and ends the cycle.
// - Elapsed time counts from the start of the whole cycle.
// - Remaining time; idle it equals high plus low interval.
// - Interval settings span 0.00000 through 999999 minutes.
// - Intervals below one scan period count as one scan period.
// - Adaptive scaling only when the fraction input is connected, 0 to 1.
// - Adaptive, low zero: cycle stays high interval, high part scaled.
// - Adaptive, low nonzero: scaled high then low interval.
// - Retain set: hot and warm keep state, cold clears it.
// - Retain clear: only hot keeps state, warm and cold clear.
`timescale 1ns/1ns
module rct_timer #(
	parameter int TIME_W = rct_pkg::TIME_W_DEF,
	parameter int FRAC_W = rct_pkg::FRAC_W_DEF
)
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_scan_tick,
	input wire logic i_run_request,
	input wire logic [TIME_W-1:0] i_high_interval,
	input wire logic [TIME_W-1:0] i_low_interval,
	input wire logic [TIME_W-1:0] i_scan_period,
	input wire logic [FRAC_W-1:0] i_on_fraction_input,
	input wire logic i_on_fraction_connected,
	input wire logic i_retain_on_restart,
	input wire logic i_restart_pulse,
	input wire logic [1:0] i_restart_type,
	output logic o_pulse_output,
	output logic [TIME_W-1:0] o_elapsed_cycle_time,
	output logic [TIME_W-1:0] o_remaining_cycle_time,
	output logic o_running,
	output logic o_cycle_wrap
);

	// Refuse widths the arithmetic cannot serve
	generate
		if (TIME_W < rct_pkg::TIME_W_MIN)
		begin : g_time_w_check
			$error("rct_timer: TIME_W too small for the setting range");
		end
		if (FRAC_W < rct_pkg::FRAC_W_MIN)
		begin : g_frac_w_check
			$error("rct_timer: FRAC_W too small");
		end
	endgenerate

	// Whole state of the block
	typedef struct packed {
		rct_pkg::rct_state_t phase;
		logic [TIME_W-1:0] elapsed;
		logic [TIME_W-1:0] remaining;
		logic pulse;
		logic run_seen;
		logic wrap;
	} rct_regs_t;

	rct_regs_t st_reg;
	rct_regs_t st_next;

	logic [TIME_W:0] on_len;
	logic [TIME_W:0] cycle_len;
	logic [TIME_W:0] idle_total;

	// Phase lengths from the settings
	rct_interval_calc #(
		.TIME_W(TIME_W),
		.FRAC_W(FRAC_W)
	) u_calc (
		.i_high_interval(i_high_interval),
		.i_low_interval(i_low_interval),
		.i_scan_period(i_scan_period),
		.i_on_fraction_input(i_on_fraction_input),
		.i_on_fraction_connected(i_on_fraction_connected),
		.o_on_len(on_len),
		.o_cycle_len(cycle_len),
		.o_idle_total(idle_total)
	);

	// Saturate a wide time value into the output width
	function automatic logic [TIME_W-1:0] sat_time(
		input logic [TIME_W:0] v
	);
		logic [TIME_W-1:0] r;
		r = v[TIME_W] ? '1 : v[TIME_W-1:0];
		return r;
	endfunction

	// Remaining time of a cycle, never below zero
	function automatic logic [TIME_W-1:0] left_time(
		input logic [TIME_W:0] cyc,
		input logic [TIME_W-1:0] el
	);
		logic [TIME_W:0] d;
		d = (cyc > {1'b0, el}) ? cyc - {1'b0, el} : '0;
		return sat_time(d);
	endfunction

	// Decide whether a restart keeps state
	function automatic logic restart_keeps(
		input logic retain,
		input logic [1:0] kind
	);
		logic k;
		k = 1'b0;
		case (kind)
			rct_pkg::RESTART_HOT: k = 1'b1;
			rct_pkg::RESTART_WARM: k = retain;
			rct_pkg::RESTART_COLD: k = 1'b0;
			default: k = 1'b0;
		endcase
		return k;
	endfunction

	logic [TIME_W:0] el_step;

	// Elapsed time one scan further on
	assign el_step = {1'b0, st_reg.elapsed} + {1'b0, i_scan_period};

	// Next state
	always_comb
	begin
		st_next = st_reg;
		st_next.wrap = 1'b0;
		if (i_restart_pulse)
		begin
			// keep or clear with retain set
			// keep or clear with retain clear
			if (!restart_keeps(i_retain_on_restart, i_restart_type))
			begin
				st_next.phase = rct_pkg::RCT_IDLE;
				st_next.elapsed = TIME_W'(rct_pkg::ELAPSED_RST);
				st_next.pulse = rct_pkg::PULSE_RST;
				st_next.run_seen = rct_pkg::RUN_RST;
				st_next.remaining = sat_time(idle_total);
			end
		end
		else if (!i_run_request)
		begin
			st_next.phase = rct_pkg::RCT_IDLE;
			st_next.pulse = 1'b0;
			st_next.run_seen = 1'b0;
			st_next.elapsed = '0;
			// idle remaining is high plus low interval
			// Shown at once, so a stopped timer never waits for a tick
			st_next.remaining = sat_time(idle_total);
		end
		else if (i_scan_tick)
		begin
			st_next.run_seen = 1'b1;
			case (st_reg.phase)
				rct_pkg::RCT_IDLE:
				begin
					st_next.elapsed = '0;
					st_next.pulse = (on_len != '0);
					st_next.phase = (on_len != '0) ? rct_pkg::RCT_HIGH
						: rct_pkg::RCT_LOW;
					st_next.remaining = sat_time(cycle_len);
				end
				rct_pkg::RCT_HIGH,
				rct_pkg::RCT_LOW:
				begin
					if (el_step >= cycle_len)
					begin
						st_next.elapsed = '0;
						st_next.wrap = 1'b1;
						st_next.pulse = (on_len != '0);
						st_next.phase = (on_len != '0) ? rct_pkg::RCT_HIGH
							: rct_pkg::RCT_LOW;
						st_next.remaining = sat_time(cycle_len);
					end
					else
					begin
						st_next.elapsed = el_step[TIME_W-1:0];
						st_next.pulse = (el_step < on_len);
						st_next.phase = (el_step < on_len) ? rct_pkg::RCT_HIGH
							: rct_pkg::RCT_LOW;
						st_next.remaining = left_time(cycle_len,
							el_step[TIME_W-1:0]);
					end
				end
				default:
				begin
					st_next.phase = rct_pkg::RCT_IDLE;
					st_next.pulse = 1'b0;
					st_next.elapsed = '0;
				end
			endcase
		end
		else if (st_reg.phase == rct_pkg::RCT_IDLE)
		begin
			// Idle between ticks shows high plus low interval
			st_next.remaining = sat_time(idle_total);
		end
	end

	// State register
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			st_reg.phase <= rct_pkg::RCT_IDLE;
			st_reg.elapsed <= TIME_W'(rct_pkg::ELAPSED_RST);
			st_reg.remaining <= '0;
			st_reg.pulse <= rct_pkg::PULSE_RST;
			st_reg.run_seen <= rct_pkg::RUN_RST;
			st_reg.wrap <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign o_pulse_output = st_reg.pulse;
	assign o_elapsed_cycle_time = st_reg.elapsed;
	assign o_remaining_cycle_time = st_reg.remaining;
	assign o_running = st_reg.run_seen;
	assign o_cycle_wrap = st_reg.wrap;

endmodule // rct_timer

// ===== include/rct_pkg.sv
// Package for the repeat cycle timer: widths, limits, codes and states.
// Assumes times are unsigned counts of 0.00001 minute.
package rct_pkg;

	// Default width of a time value in 0.00001 minute units
	localparam int TIME_W_DEF = 40;
	// Default width of the on-fraction input, 1.0 = 2**(FRAC_W-1)
	localparam int FRAC_W_DEF = 16;
	// Least time width that holds the largest setting
	localparam int TIME_W_MIN = 37;
	// Least fraction width that still has a fraction bit
	localparam int FRAC_W_MIN = 2;

	// Largest interval setting, 999999.00000 minutes in 0.00001 units
	localparam logic [39:0] MAX_SETTING = 40'h1748756160;

	// Reset values of the timer state
	localparam logic [39:0] ELAPSED_RST = 40'h0000000000;
	localparam logic PULSE_RST = 1'b0;
	localparam logic RUN_RST = 1'b0;

	// Restart type codes
	localparam logic [1:0] RESTART_HOT = 2'h0;
	localparam logic [1:0] RESTART_WARM = 2'h1;
	localparam logic [1:0] RESTART_COLD = 2'h2;

	// Timer phase
	typedef enum logic [1:0]
	{
		RCT_IDLE = 2'b00,
		RCT_HIGH = 2'b01,
		RCT_LOW = 2'b10
	} rct_state_t;

endpackage

// ===== rtl/rct_interval_calc.sv
// Interval calculation: clamps settings and derives high time and cycle.
// Assumes settings and scan period in the same 0.00001 minute units.
`timescale 1ns/1ns
module rct_interval_calc #(
	parameter int TIME_W = rct_pkg::TIME_W_DEF,
	parameter int FRAC_W = rct_pkg::FRAC_W_DEF
)
(
	input wire logic [TIME_W-1:0] i_high_interval,
	input wire logic [TIME_W-1:0] i_low_interval,
	input wire logic [TIME_W-1:0] i_scan_period,
	input wire logic [FRAC_W-1:0] i_on_fraction_input,
	input wire logic i_on_fraction_connected,
	output logic [TIME_W:0] o_on_len,
	output logic [TIME_W:0] o_cycle_len,
	output logic [TIME_W:0] o_idle_total
);

	localparam logic [FRAC_W-1:0] FRAC_ONE = FRAC_W'(1) << (FRAC_W - 1);
	localparam logic [TIME_W-1:0] MAX_SET = TIME_W'(rct_pkg::MAX_SETTING);

	// Limit to the display range, then to at least one scan period
	function automatic logic [TIME_W-1:0] clamp_setting(
		input logic [TIME_W-1:0] v,
		input logic [TIME_W-1:0] scan
	);
		logic [TIME_W-1:0] r;
		r = (v > MAX_SET) ? MAX_SET : v;
		if (r < scan)
			r = scan;
		return r;
	endfunction

	logic [TIME_W-1:0] high_c;
	logic [TIME_W-1:0] low_c;
	logic [FRAC_W-1:0] frac_c;
	logic [TIME_W+FRAC_W-1:0] prod;
	logic [TIME_W-1:0] on_scaled;
	logic low_is_zero;

	assign high_c = clamp_setting(i_high_interval, i_scan_period);
	assign low_c = clamp_setting(i_low_interval, i_scan_period);
	assign low_is_zero = (i_low_interval == '0);

	assign frac_c = (i_on_fraction_input > FRAC_ONE) ? FRAC_ONE
		: i_on_fraction_input;
	assign prod = high_c * frac_c;
	assign on_scaled = prod[TIME_W+FRAC_W-2:FRAC_W-1];

	// Phase lengths for plain and adaptive modes
	always_comb
	begin
		o_idle_total = {1'b0, high_c} + {1'b0, low_c};
		if (!i_on_fraction_connected)
		begin
			o_on_len = {1'b0, high_c};
			o_cycle_len = {1'b0, high_c} + {1'b0, low_c};
		end
		else if (low_is_zero)
		begin
			o_on_len = {1'b0, on_scaled};
			o_cycle_len = {1'b0, high_c};
		end
		else
		begin
			o_on_len = {1'b0, on_scaled};
			o_cycle_len = {1'b0, on_scaled} + {1'b0, low_c};
		end
	end

endmodule // rct_interval_calc

// ===== dv/rct_scan_src.sv
// Scan tick source standing in for the controller scan sequencer.
// Assumes one clock; ticks are one clock wide, GAP clocks apart.
`timescale 1ns/1ns
module rct_scan_src #(
	parameter int GAP = 3
)
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	output logic o_scan_tick
);
	int cnt;
	// One tick per GAP clocks; GAP of 1 gives back to back ticks
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
		begin
			cnt <= 0;
			o_scan_tick <= 1'b0;
		end
		else
		begin
			cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
			o_scan_tick <= cnt == GAP - 1;
		end
endmodule // rct_scan_src

// ===== dv/rct_timer_monitor.sv
// Checker on the repeat cycle timer ports.
// Assumes one clock with an async active-high reset.
`timescale 1ns/1ns
module rct_timer_monitor #(
	parameter int TIME_W = 40,
	parameter int FRAC_W = 16
)
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_scan_tick,
	input wire logic i_run_request,
	input wire logic [TIME_W-1:0] i_high_interval,
	input wire logic [TIME_W-1:0] i_low_interval,
	input wire logic [TIME_W-1:0] i_scan_period,
	input wire logic i_on_fraction_connected,
	input wire logic i_retain_on_restart,
	input wire logic i_restart_pulse,
	input wire logic [1:0] i_restart_type,
	input wire logic o_pulse_output,
	input wire logic [TIME_W-1:0] o_elapsed_cycle_time,
	input wire logic [TIME_W-1:0] o_remaining_cycle_time,
	input wire logic o_running,
	input wire logic o_cycle_wrap
);
	logic ok_set;
	// Settings inside the span, so no clamping applies
	assign ok_set = i_high_interval >= i_scan_period
		&& i_low_interval >= i_scan_period
		&& i_high_interval <= rct_pkg::MAX_SETTING
		&& i_low_interval <= rct_pkg::MAX_SETTING;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	sequence plain_run;
		o_running && !i_on_fraction_connected && ok_set;
	endsequence
	sequence idle_two;
		(!i_run_request && !i_restart_pulse && ok_set
			&& $stable(i_high_interval) && $stable(i_low_interval))[*2];
	endsequence
	run_drop_a:
	assert property (!i_run_request && !i_restart_pulse |=> !o_pulse_output
		&& !o_running) else $error("pulse kept after run drop");
	idle_sum_a:
	assert property (idle_two |=> o_remaining_cycle_time
		== $past(i_high_interval + i_low_interval)) else $error("idle sum");
	step_a:
	assert property (i_scan_tick && i_run_request && !i_restart_pulse
		&& o_running |=> o_cycle_wrap ? o_elapsed_cycle_time == '0
		: o_elapsed_cycle_time == $past(o_elapsed_cycle_time + i_scan_period))
		else $error("elapsed step");
	hold_a:
	assert property (o_running && i_run_request && !i_scan_tick
		&& !i_restart_pulse |=> $stable(o_elapsed_cycle_time)
		&& $stable(o_pulse_output)) else $error("moved without tick");
	remain_a:
	assert property (plain_run |-> o_remaining_cycle_time
		+ o_elapsed_cycle_time == i_high_interval + i_low_interval)
		else $error("remaining plus elapsed");
	phase_a:
	assert property (plain_run |-> o_pulse_output
		== (o_elapsed_cycle_time < i_high_interval)) else $error("phase");
	wrap_a:
	assert property (plain_run ##0 o_cycle_wrap |-> o_pulse_output
		&& o_elapsed_cycle_time == '0) else $error("wrap");
	clear_a:
	assert property (i_restart_pulse && i_restart_type != 2'h0
		&& !(i_retain_on_restart && i_restart_type == 2'h1) |=> !o_running
		&& o_elapsed_cycle_time == '0) else $error("restart clear");
	keep_a:
	assert property (i_restart_pulse && (i_restart_type == 2'h0
		|| i_retain_on_restart && i_restart_type == 2'h1)
		|=> $stable(o_elapsed_cycle_time)) else $error("restart keep");
endmodule // rct_timer_monitor

bind rct_timer rct_timer_monitor #(.TIME_W(TIME_W), .FRAC_W(FRAC_W)) u_mon (.*);

// ===== dv/rct_timer_test.sv
// Self-checking bench for the repeat cycle timer.
// Assumes the scan source model ticks every third clock.
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
	$display("BAD %0t got %h exp %h", $time, a, b); end end
module rct_timer_test;
	logic clk = 1'b0, rst = 1'b1, run = 1'b0, conn = 1'b0, ret = 1'b0;
	logic rs = 1'b0, tick, pulse, running, keep, wrap;
	logic [1:0] kind = 2'h0;
	logic [39:0] hi = 40'h3, lo = 40'h2, el, rem;
	logic [15:0] frac = 16'h4000;
	int n_fail = 0, cmp_count = 0, cyc = 0;
	rct_scan_src u_src (.i_sys_clk(clk), .i_rst(rst), .o_scan_tick(tick));
	rct_timer u_dut (.i_sys_clk(clk), .i_rst(rst), .i_scan_tick(tick),
		.i_run_request(run), .i_high_interval(hi), .i_low_interval(lo),
		.i_scan_period(40'h1), .i_on_fraction_input(frac),
		.i_on_fraction_connected(conn), .i_retain_on_restart(ret),
		.i_restart_pulse(rs), .i_restart_type(kind), .o_pulse_output(pulse),
		.o_elapsed_cycle_time(el), .o_remaining_cycle_time(rem),
		.o_running(running), .o_cycle_wrap(wrap));
	initial forever #5 clk = ~clk;
	// Cut a hang short
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Wait for a taken tick, then look at settled outputs
	task automatic tk(input logic p, input logic [39:0] e, c);
		do @(posedge clk); while (!tick);
		#1;
		`CHK(pulse, p)
		`CHK(el, e)
		`CHK(rem, c - e)
	endtask
	// Run n ticks of a cycle of cl ticks, high for hl, then drop run
	task automatic seq(input logic [39:0] h, l, input logic c,
		input int n, hl, cl);
		@(posedge clk);
		hi <= h;
		lo <= l;
		conn <= c;
		run <= 1'b1;
		for (int k = 0; k < n; k++)
		begin
			tk(k % cl < hl, k % cl, cl);
			`CHK(wrap, k > 0 && k % cl == 0)
		end
		@(posedge clk);
		run <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(pulse, 1'b0)
		@(posedge clk);
		#1;
		`CHK(rem, (h < 1 ? 40'h1 : h) + (l < 1 ? 40'h1 : l))
		$display("sequence done at %0t", $time);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(rem, 40'h5)
		seq(40'h3, 40'h2, 1'b0, 12, 3, 5);
		seq(40'h0, 40'h0, 1'b0, 6, 1, 2);
		seq(40'h4, 40'h0, 1'b1, 8, 2, 4);
		seq(40'h4, 40'h3, 1'b1, 10, 2, 5);
		seq(40'h4, 40'h3, 1'b0, 7, 4, 7);
		@(posedge clk);
		hi <= 40'hFFFFFFFFFF;
		lo <= 40'hFFFFFFFFFF;
		repeat (2) @(posedge clk);
		#1;
		`CHK(rem, rct_pkg::MAX_SETTING + rct_pkg::MAX_SETTING)
		$display("clamp done at %0t", $time);
		for (int r = 0; r < 2; r++)
			for (int t = 0; t < 4; t++)
			begin
				@(posedge clk);
				hi <= 40'h3;
				lo <= 40'h2;
				ret <= r[0];
				kind <= t[1:0];
				run <= 1'b1;
				keep = t == 0 || r == 1 && t == 1;
				tk(1'b1, 40'h0, 40'h5);
				tk(1'b1, 40'h1, 40'h5);
				@(posedge clk);
				rs <= 1'b1;
				@(posedge clk);
				rs <= 1'b0;
				run <= 1'b0;
				#1;
				`CHK(el, {39'h0, keep})
				`CHK(running, keep)
				repeat (2) @(posedge clk);
			end
		$display("restart done at %0t", $time);
		wrap_up();
	end
endmodule // rct_timer_test
